/* inc/rfpl_pkg.sv */
/*
  rfpl_pkg: constants, types and preset tables for the rf protocol register loader.
  assumes a byte-wide frontend configuration register space and one 200 MHz clock.
*/
package rfpl_pkg;

  // software register port
  localparam int              RFPL_AW      = 4;
  localparam logic [3:0]      REG_CMD      = 4'h0;
  localparam logic [3:0]      REG_STATUS   = 4'h1;
  localparam logic [3:0]      REG_EE_ADDR  = 4'h2;
  localparam logic [3:0]      REG_EE_DATA  = 4'h3;
  localparam int              CMD_RATE_LSB = 0;
  localparam int              CMD_LOAD_BIT = 4;
  localparam int              CMD_COPY_BIT = 5;

  // protocol table: registers written in table order from this base
  localparam logic [7:0]      PROTO_BASE   = 8'h40;
  localparam logic [4:0]      PROTO_LAST   = 5'h17;
  localparam logic [4:0]      IX_TX_BITMOD = 5'h00;
  localparam logic [4:0]      IX_TX_RATE   = 5'h02;
  localparam logic [4:0]      IX_TX_DATMOD = 5'h03;
  localparam logic [4:0]      IX_TX_FREQ   = 5'h04;
  localparam logic [4:0]      IX_TX_PAIRHI = 5'h0f;
  localparam logic [4:0]      IX_RX_BITMOD = 5'h10;
  localparam logic [4:0]      IX_RX_SYNCL  = 5'h13;
  localparam logic [4:0]      IX_RX_MODE   = 5'h15;
  localparam logic [4:0]      IX_RX_CORR   = 5'h16;
  localparam logic [4:0]      IX_FAB_CAL   = 5'h17;
  localparam logic [7:0]      VAL_TX_BITMOD = 8'h20;
  localparam logic [7:0]      VAL_TX_RATE0  = 8'h04;
  localparam logic [7:0]      VAL_TX_MOD    = 8'h50;
  localparam logic [7:0]      VAL_TX_FREQ0  = 8'h40;
  localparam logic [7:0]      VAL_TX_FSTEP  = 8'h10;
  localparam logic [7:0]      VAL_RX_BIT106 = 8'h02;
  localparam logic [7:0]      VAL_RX_BITHI  = 8'h22;
  localparam logic [7:0]      VAL_RX_SYN106 = 8'h01;
  localparam logic [7:0]      VAL_RX_SYNHI  = 8'h00;
  localparam logic [7:0]      VAL_RX_MOD106 = 8'h08;
  localparam logic [7:0]      VAL_RX_MODHI  = 8'h0d;
  localparam logic [7:0]      VAL_RX_CORR   = 8'h80;
  localparam logic [7:0]      VAL_FAB_CAL   = 8'hb2;

  // antenna registers and user eeprom
  localparam logic [7:0]      ANT_FIRST    = 8'h28;
  localparam logic [7:0]      ANT_LAST     = 8'h39;
  localparam logic [4:0]      ANT_CNT_LAST = 5'h11;
  localparam logic [7:0]      EE_FIRST     = 8'hc0;
  localparam int              EE_DEPTH     = 38;
  localparam logic [5:0]      EE_BASE_106  = 6'h00;
  localparam logic [5:0]      EE_BASE_212  = 6'h14;
  localparam logic [0:17][7:0] EE_PRESET_106 = {8'h8e, 8'h12, 8'h39, 8'h0a, 8'h18, 8'h18, 8'h0f, 8'h21, 8'h00,
                                                8'hc0, 8'h12, 8'hcf, 8'h00, 8'h04, 8'h90, 8'h5c, 8'h12, 8'h0a};
  localparam logic [0:17][7:0] EE_PRESET_212 = {8'h8e, 8'hd2, 8'h11, 8'h0a, 8'h18, 8'h18, 8'h0f, 8'h10, 8'h00,
                                                8'hc0, 8'h12, 8'hcf, 8'h00, 8'h05, 8'h90, 8'h3c, 8'h12, 8'h0b};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_COPY = 3'b100
  } rfpl_state_e;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rfpl_cfgwr_s;

endpackage : rfpl_pkg

/* rtl/rfpl_loader.sv */
/*
  rfpl_loader: protocol preset loader and eeprom-to-antenna copier for the rf frontend.
  assumes the frontend register file takes one byte write per cycle on cfgWr, and that
  the software register port runs on clk.
*/
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module rfpl_loader
  import rfpl_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // software register port
  input  wire logic [RFPL_AW-1:0] regAddr,
  input  wire logic [7:0]         regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [7:0]         regRdata,
  // frontend register write port
  output rfpl_cfgwr_s             cfgWr,
  output logic                    busy
);

  rfpl_state_e       state;
  rfpl_state_e       next_state;
  logic [4:0]        idx;
  logic [4:0]        next_idx;
  logic [1:0]        rate;
  logic [1:0]        next_rate;
  logic              isCopy;
  logic              next_isCopy;
  logic              err;
  logic              next_err;
  logic              next_busy;
  rfpl_cfgwr_s       next_cfgWr;
  logic [7:0]        eeMem [EE_DEPTH];
  logic [7:0]        next_eeMem [EE_DEPTH];
  logic [7:0]        eeAddr;
  logic [7:0]        next_eeAddr;
  logic [7:0]        next_regRdata;
  logic              eeHit;
  logic [5:0]        eeIx;
  logic [5:0]        copyIx;

  function automatic logic [7:0] protoValue(input logic [1:0] r, input logic [4:0] i);
    logic lowRate;
    lowRate = (r == 2'd0);
    case (i)
      IX_TX_BITMOD: protoValue = VAL_TX_BITMOD;
      IX_TX_RATE:   protoValue = VAL_TX_RATE0 + {6'h00, r};
      IX_TX_DATMOD: protoValue = VAL_TX_MOD;
      IX_TX_FREQ:   protoValue = VAL_TX_FREQ0 + VAL_TX_FSTEP * {6'h00, r};
      IX_TX_PAIRHI: protoValue = VAL_TX_MOD;
      IX_RX_BITMOD: protoValue = lowRate ? VAL_RX_BIT106 : VAL_RX_BITHI;
      IX_RX_SYNCL:  protoValue = lowRate ? VAL_RX_SYN106 : VAL_RX_SYNHI;
      IX_RX_MODE:   protoValue = lowRate ? VAL_RX_MOD106 : VAL_RX_MODHI;
      IX_RX_CORR:   protoValue = VAL_RX_CORR;
      IX_FAB_CAL:   protoValue = VAL_FAB_CAL;
      default:      protoValue = 8'h00;
    endcase
  endfunction : protoValue

  function automatic logic [7:0] eeDefault(input int i);
    if (i < 18) begin
      eeDefault = EE_PRESET_106[i];
    end else if (i >= 20 && i < 38) begin
      eeDefault = EE_PRESET_212[i - 20];
    end else begin
      eeDefault = 8'h00;
    end
  endfunction : eeDefault

  assign eeHit  = (eeAddr >= EE_FIRST) && ((eeAddr - EE_FIRST) < 8'(EE_DEPTH));
  assign eeIx   = 6'(eeAddr - EE_FIRST);
  assign copyIx = ((rate == 2'd0) ? EE_BASE_106 : EE_BASE_212) + {1'b0, idx};

  // sequencer
  always_comb begin
    next_state  = state;
    next_idx    = idx;
    next_rate   = rate;
    next_isCopy = isCopy;
    next_err    = err;
    next_cfgWr  = '0;
    case (state)
      ST_IDLE: begin
        if (regWr && regAddr == REG_CMD) begin
          if (regWdata[CMD_LOAD_BIT]) begin
            next_state  = ST_LOAD;
            next_rate   = regWdata[CMD_RATE_LSB +: 2];
            next_isCopy = 1'b0;
            next_idx    = '0;
            next_err    = 1'b0;
          end else if (regWdata[CMD_COPY_BIT]) begin
            // only the 106 and 212 antenna blocks are held on chip
            next_rate   = regWdata[CMD_RATE_LSB +: 2];
            next_isCopy = 1'b1;
            next_idx    = '0;
            next_err    = regWdata[CMD_RATE_LSB + 1];
            next_state  = regWdata[CMD_RATE_LSB + 1] ? ST_IDLE : ST_COPY;
          end
        end
      end
      ST_LOAD: begin
        next_cfgWr.en   = 1'b1;
        next_cfgWr.addr = PROTO_BASE + {3'h0, idx};
        next_cfgWr.data = protoValue(rate, idx);
        next_idx        = idx + 5'h01;
        if (idx == PROTO_LAST) begin
          next_state = ST_IDLE;
        end
      end
      ST_COPY: begin
        next_cfgWr.en   = 1'b1;
        next_cfgWr.addr = ANT_FIRST + {3'h0, idx};
        next_cfgWr.data = eeMem[copyIx];
        next_idx        = idx + 5'h01;
        if (idx == ANT_CNT_LAST) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a command while busy is dropped; flag it so software can tell
    if (state != ST_IDLE && regWr && regAddr == REG_CMD &&
        (regWdata[CMD_LOAD_BIT] || regWdata[CMD_COPY_BIT])) begin
      next_err = 1'b1;
    end
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state  <= ST_IDLE;
      idx    <= '0;
      rate   <= '0;
      isCopy <= 1'b0;
      err    <= 1'b0;
      busy   <= 1'b0;
      cfgWr  <= '0;
    end else begin
      state  <= next_state;
      idx    <= next_idx;
      rate   <= next_rate;
      isCopy <= next_isCopy;
      err    <= next_err;
      busy   <= next_busy;
      cfgWr  <= next_cfgWr;
    end
  end

  // user eeprom; software may retune presets before copying
  always_comb begin
    next_eeMem  = eeMem;
    next_eeAddr = eeAddr;
    if (regWr && regAddr == REG_EE_ADDR) begin
      next_eeAddr = regWdata;
    end
    if (regWr && regAddr == REG_EE_DATA && eeHit) begin
      next_eeMem[eeIx] = regWdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eeAddr <= '0;
      for (int i = 0; i < EE_DEPTH; i++) begin
        eeMem[i] <= eeDefault(i);
      end
    end else begin
      eeAddr <= next_eeAddr;
      eeMem  <= next_eeMem;
    end
  end

  // read data only in the cycle after the strobe
  always_comb begin
    next_regRdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        REG_STATUS:  next_regRdata = {3'h0, isCopy, rate, err, busy};
        REG_EE_ADDR: next_regRdata = eeAddr;
        REG_EE_DATA: next_regRdata = eeHit ? eeMem[eeIx] : 8'h00;
        default:     next_regRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  a_load_length:
  assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(state == ST_LOAD)) |-> (state == ST_LOAD) [*8] ##1 (state == ST_LOAD) [*8] ##1 (state == ST_LOAD) [*8]
      ##1 (state == ST_IDLE))
    else $error("load sequence length wrong");

  a_load_no_antenna:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && !isCopy) |-> !(cfgWr.addr >= ANT_FIRST && cfgWr.addr <= ANT_LAST))
    else $error("load wrote an antenna register");

  a_rate_ctrl_val:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && !isCopy && cfgWr.addr == PROTO_BASE + 8'h02) |-> (cfgWr.data == 8'h04 + {6'h00, rate}))
    else $error("tx rate control value wrong");

  a_sym_freq_val:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && !isCopy && cfgWr.addr == PROTO_BASE + 8'h04) |-> (cfgWr.data[3:0] == 4'h0 &&
     cfgWr.data[7:4] == 4'h4 + {2'b00, rate}))
    else $error("tx symbol frequency wrong");

  a_rx_mode_val:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && !isCopy && cfgWr.addr == PROTO_BASE + 8'h15) |-> (cfgWr.data == ((rate == 2'd0) ? 8'h08 : 8'h0d)))
    else $error("rx mode value wrong");

  a_fixed_cal_val:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && !isCopy && cfgWr.addr == PROTO_BASE + 8'h17) |-> (cfgWr.data == 8'hb2) ##1 !cfgWr.en)
    else $error("calibration value or end wrong");

  a_copy_in_range:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && isCopy) |-> (cfgWr.addr >= ANT_FIRST && cfgWr.addr <= ANT_LAST))
    else $error("copy outside antenna range");

  a_copy_first_byte:
  assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(state == ST_COPY)) |-> ##1 (cfgWr.en && cfgWr.addr == 8'h28 && cfgWr.data == $past(eeMem[copyIx])))
    else $error("copy first byte wrong");

  a_table_order:
  assert property (@(posedge clk) disable iff (sys_rst)
    (cfgWr.en && $past(cfgWr.en)) |-> (cfgWr.addr == $past(cfgWr.addr) + 8'h01))
    else $error("writes out of order");

endmodule : rfpl_loader

/* tb/rfpl_regfile_model.sv */
/*
  rfpl_regfile_model: frontend register file on the loader's write port, logging every cfgWr write.
  assumes one byte write per clk on cfgWr or on the host's own single-register port;
  the bench pulses clrLog between commands.
*/
`timescale 1ns/1ps
module rfpl_regfile_model
  import rfpl_pkg::*;
(
  // clock
  input wire logic        clk,
  // loader write port
  input wire rfpl_cfgwr_s cfgWr,
  // host single-register writes and log clear
  input wire rfpl_cfgwr_s hostWr,
  input wire logic        clrLog
);
  logic [7:0] wrAddr[$];
  logic [7:0] wrData[$];
  int         runCount = 0;
  logic       prevEn   = 1'b0;
  logic [7:0] regs [256] = '{default: 8'h00};
  // a gap inside a sequence shows up as a second run
  always @(posedge clk) begin
    if (clrLog === 1'b1) begin
      wrAddr.delete();
      wrData.delete();
      runCount = 0;
    end
    if (cfgWr.en === 1'b1) begin
      wrAddr.push_back(cfgWr.addr);
      wrData.push_back(cfgWr.data);
      regs[cfgWr.addr] <= cfgWr.data;
      if (prevEn !== 1'b1) runCount++;
    end
    // host writes only while the loader is idle
    if (hostWr.en === 1'b1) begin
      regs[hostWr.addr] <= hostWr.data;
    end
    prevEn <= cfgWr.en;
  end
endmodule : rfpl_regfile_model

/* tb/rfpl_loader_tb.sv */
/*
  rfpl_loader_tb: self-checking bench for the protocol loader and eeprom copier.
  assumes the register port of the notes and the frontend model on cfgWr.
*/
`timescale 1ns/1ps
module rfpl_loader_tb;
  import rfpl_pkg::*;
  logic               clk       = 1'b0;
  logic               sys_rst   = 1'b1;
  logic [RFPL_AW-1:0] regAddr   = '0;
  logic [7:0]         regWdata  = 8'h00;
  logic               regWr     = 1'b0;
  logic               regRd     = 1'b0;
  logic [7:0]         regRdata;
  rfpl_cfgwr_s        cfgWr;
  logic               busy;
  rfpl_cfgwr_s        hostWr    = '0;
  logic               clrLog    = 1'b0;
  int                 err_count = 0;
  int                 cmp_count = 0;
  int                 cycles    = 0;
  logic [7:0]         eeA[4]    = '{8'hc0, 8'hd0, 8'hd4, 8'he5};
  logic [7:0]         eeD[4]    = '{8'h8e, 8'h12, 8'h8e, 8'h0b};

  always #2.5 clk = ~clk;

  rfpl_loader uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
                   .regRd(regRd), .regRdata(regRdata), .cfgWr(cfgWr), .busy(busy));
  rfpl_regfile_model fe (.clk(clk), .cfgWr(cfgWr), .hostWr(hostWr), .clrLog(clrLog));

  task automatic complete_run;
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  // ceiling with margin: the whole sequence needs about four hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic clear_log;
    @(posedge clk);
    clrLog <= 1'b1;
    @(posedge clk);
    clrLog <= 1'b0;
  endtask : clear_log

  // host side single-register write into the frontend, loader idle
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hostWr <= '{1'b1, a, d};
    @(posedge clk);
    hostWr <= '0;
  endtask : host_wr

  // busy is read just past each edge, where it has settled
  task automatic settle(input int n);
    int k = 0;
    repeat (3) @(posedge clk);
    #1;
    while (busy !== 1'b0 && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (2) @(posedge clk);
    #1;
    chk("busy end", 8'h00, {7'h00, busy});
    chk("write count", 8'(n), 8'(fe.wrAddr.size()));
    chk("write runs", (n > 0) ? 8'h01 : 8'h00, 8'(fe.runCount));
  endtask : settle

  task automatic cmd(input logic [7:0] d, input int n);
    clear_log();
    wr(REG_CMD, d);
    #1 chk("busy start", (n > 0) ? 8'h01 : 8'h00, {7'h00, busy});
    settle(n);
  endtask : cmd

  function automatic logic [7:0] load_val(input int r, input int i);
    case (i)
      0:       return 8'h20;
      2:       return 8'h04 + 8'(r);
      3, 15:   return 8'h50;
      4:       return 8'h40 + 8'(16 * r);
      16:      return (r == 0) ? 8'h02 : 8'h22;
      19:      return (r == 0) ? 8'h01 : 8'h00;
      21:      return (r == 0) ? 8'h08 : 8'h0d;
      22:      return 8'h80;
      23:      return 8'hb2;
      default: return 8'h00;
    endcase
  endfunction : load_val

  initial begin
    logic [7:0] v;
    int         r;
    int         i;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_STATUS, v);
    chk("status reset", 8'h00, v);
    wr(4'h7, 8'hff);
    rd(4'h7, v);
    chk("unmapped", 8'h00, v);
    for (r = 0; r < 4; r++) begin
      cmd(8'h10 | 8'(r), 24);
      for (i = 0; i < 24; i++) begin
        chk("load addr", 8'h40 + 8'(i), fe.wrAddr[i]);
        chk("load data", load_val(r, i), fe.wrData[i]);
      end
    end
    // no presets on this path: host fills the antenna range itself
    for (i = 0; i < 18; i++) begin
      host_wr(8'h28 + 8'(i), 8'ha0 + 8'(i));
    end
    // load and copy both set: load wins
    cmd(8'h31, 24);
    chk("load wins", 8'h50, fe.wrData[4]);
    rd(REG_STATUS, v);
    chk("status load wins", 8'h04, v);
    for (i = 0; i < 18; i++) begin
      chk("antenna kept", 8'ha0 + 8'(i), fe.regs[8'h28 + 8'(i)]);
    end
    chk("above load set", 8'h00, fe.regs[8'h58]);
    chk("below load set", 8'h00, fe.regs[8'h3f]);
    for (r = 0; r < 2; r++) begin
      cmd(8'h20 | 8'(r), 18);
      for (i = 0; i < 18; i++) begin
        chk("copy addr", 8'h28 + 8'(i), fe.wrAddr[i]);
        chk("copy data", (r == 0) ? EE_PRESET_106[i] : EE_PRESET_212[i], fe.wrData[i]);
      end
    end
    foreach (eeA[k]) begin
      wr(REG_EE_ADDR, eeA[k]);
      rd(REG_EE_DATA, v);
      chk("eeprom", eeD[k], v);
    end
    wr(REG_EE_ADDR, 8'hc5);
    wr(REG_EE_DATA, 8'h5a);
    cmd(8'h20, 18);
    chk("copy edited", 8'h5a, fe.wrData[5]);
    cmd(8'h22, 0);
    rd(REG_STATUS, v);
    chk("err copy", 8'h02, v & 8'h02);
    clear_log();
    // second command lands while the first is still running
    wr(REG_CMD, 8'h10);
    wr(REG_CMD, 8'h21);
    settle(24);
    rd(REG_STATUS, v);
    chk("err busy", 8'h02, v & 8'h02);
    cmd(8'h13, 24);
    rd(REG_STATUS, v);
    chk("status load", 8'h0c, v);
    // reset lands while a load is running: no byte may follow it
    clear_log();
    wr(REG_CMD, 8'h10);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle(0);
    rd(REG_STATUS, v);
    chk("status after reset", 8'h00, v);
    wr(REG_EE_ADDR, 8'hc5);
    rd(REG_EE_DATA, v);
    chk("eeprom default", 8'h18, v);
    complete_run();
  end
endmodule : rfpl_loader_tb
